// >>> logic/mcr_dev.sv
// module: modulator end, calibration muxing, standby, reset, valid flag
//
// Functional notes
// - zero cal: ground unipolar, reference bipolar
// - reader waits 1000 cycles after zero cal
// - zero cal density 50% bipolar, 37.5% unipolar
// - gain cal: neg input ground, pos reference
// - gain cal density 62.5%, wait 1000
// - reader resets modulator before any calibration
// - recalibrate after any input mode change
// - standby stops modulator clock, removes bias
// - reset clears integrators, flag low 20 after
// - reader waits 1000 cycles after reset
// - instability resets modulator, flag low 20
// - flag low marks overrange invalid data
// - one output bit per master clock
`default_nettype none
module mcr_dev #(
   parameter int unsigned ACC_W    = 16,
   parameter int unsigned HOLD_CYC = mcr_pkg::VALID_HOLD_CYC
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_rst,
   input  wire logic             i_ce,
   mcr_if.dev                    lnk,
   input  wire logic [ACC_W-1:0] i_pos_analog_input,
   input  wire logic [ACC_W-1:0] i_neg_analog_input,
   input  wire logic [ACC_W-1:0] i_ref_level,
   output logic                  o_bias_enable,
   output logic                  o_mod_clk_enable,
   output mcr_pkg::mcr_conn_t    o_pos_conn,
   output mcr_pkg::mcr_conn_t    o_neg_conn
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0]       sync_zc;
      logic [1:0]       sync_gc;
      logic [1:0]       sync_lp;
      logic [1:0]       sync_rs;
      logic [1:0]       sync_bp;
      logic signed [ACC_W+1:0] integ;
      logic [2:0]       phase;
      logic [4:0]       hold;
      logic             bit_q;
      logic             valid;
      logic             bias;
      logic             clken;
      mcr_pkg::mcr_conn_t pos_c;
      mcr_pkg::mcr_conn_t neg_c;
   } mcr_dev_state_t;

   mcr_dev_state_t st_ff;
   mcr_dev_state_t nxt_st;

   logic zc;
   logic gc;
   logic lp;
   logic rs;
   logic bp;
   logic [7:0] pat;
   logic signed [ACC_W+1:0] diff;
   logic signed [ACC_W+1:0] fb;
   logic signed [ACC_W+1:0] sum;
   logic unstable;

   // second stage of each synchroniser only
   assign zc = st_ff.sync_zc[1];
   assign gc = st_ff.sync_gc[1];
   assign lp = st_ff.sync_lp[1];
   assign rs = st_ff.sync_rs[1];
   assign bp = st_ff.sync_bp[1];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   // one process computes every field; the flop stage below only
   // registers it, so the clock enable gates the whole block at once
   always_comb begin
      nxt_st   = st_ff;
      pat      = 8'h00;
      diff     = '0;
      fb       = '0;
      sum      = '0;
      unstable = 1'b0;

      // ------------------------------------------------------------
      // link synchronisers
      // ------------------------------------------------------------
      // the controls may come from far across a board, so each one
      // passes two flops before any decision reads it
      nxt_st.sync_zc = {st_ff.sync_zc[0], lnk.zero_cal_select};
      nxt_st.sync_gc = {st_ff.sync_gc[0], lnk.gain_cal_select};
      nxt_st.sync_lp = {st_ff.sync_lp[0], lnk.low_power_request};
      nxt_st.sync_rs = {st_ff.sync_rs[0], lnk.mod_reset};
      nxt_st.sync_bp = {st_ff.sync_bp[0], lnk.bipolar_mode};

      // ------------------------------------------------------------
      // input routing
      // ------------------------------------------------------------
      // zero cal wins over gain cal, so a host that overlaps the two
      // never sees a mixed connection on the inputs
      if (zc) begin
         nxt_st.pos_c = bp ? mcr_pkg::MCR_IN_REF
                           : mcr_pkg::MCR_IN_GROUND;
         nxt_st.neg_c = nxt_st.pos_c;
      end else if (gc) begin
         nxt_st.pos_c = mcr_pkg::MCR_IN_REF;
         nxt_st.neg_c = mcr_pkg::MCR_IN_GROUND;
      end else begin
         nxt_st.pos_c = mcr_pkg::MCR_IN_SIGNAL;
         nxt_st.neg_c = mcr_pkg::MCR_IN_SIGNAL;
      end

      // ------------------------------------------------------------
      // standby
      // ------------------------------------------------------------
      // clock and bias follow the synced request; reset still acts in
      // standby so the loop can be cleared before it wakes
      nxt_st.clken = ~lp;
      nxt_st.bias  = ~lp;

      // ------------------------------------------------------------
      // loop arithmetic
      // ------------------------------------------------------------
      // two guard bits above the sample width; top bits that differ
      // mean the integrator has left its range
      diff = $signed({2'b00, i_pos_analog_input})
           - $signed({2'b00, i_neg_analog_input});
      fb   = st_ff.bit_q ? $signed({2'b00, i_ref_level})
                         : -$signed({2'b00, i_ref_level});
      sum  = st_ff.integ + diff - fb;
      // top two bits of sum that differ flag instability
      unstable = (sum[ACC_W+1] != sum[ACC_W]);

      // ------------------------------------------------------------
      // calibration patterns
      // ------------------------------------------------------------
      // fixed 8-bit frames give the ideal density exactly in every
      // frame; a real loop would only reach it on average
      if (zc) begin
         pat = bp ? mcr_pkg::DENS_50 : mcr_pkg::DENS_375;
      end else if (gc) begin
         pat = mcr_pkg::DENS_625;
      end

      // ------------------------------------------------------------
      // stream, hold count and valid flag
      // ------------------------------------------------------------
      // reset beats standby; the hold count reloads on reset and, outside
      // calibration, on instability and only counts down while the loop runs
      if (rs) begin
         nxt_st.integ = '0;
         nxt_st.phase = 3'h0;
         nxt_st.bit_q = 1'b0;
         nxt_st.valid = 1'b0;
         nxt_st.hold  = 5'(HOLD_CYC);
      end else if (!lp) begin
         // one bit per clock while running
         nxt_st.phase = st_ff.phase + 3'h1;
         if (zc || gc) begin
            // calibration stream is a fixed density pattern
            nxt_st.bit_q = pat[st_ff.phase];
            nxt_st.integ = '0;
         end else if (unstable) begin
            nxt_st.integ = '0;
            nxt_st.bit_q = 1'b0;
            nxt_st.valid = 1'b0;
            nxt_st.hold  = 5'(HOLD_CYC);
         end else begin
            nxt_st.integ = sum;
            nxt_st.bit_q = ~sum[ACC_W+1];
         end
         if (!unstable || zc || gc) begin
            if (st_ff.hold != 5'h00) begin
               nxt_st.hold  = st_ff.hold - 5'h01;
               nxt_st.valid = 1'b0;
            end else begin
               nxt_st.valid = 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // register; clock enable freezes everything
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff       <= '0;
         st_ff.hold  <= 5'(HOLD_CYC);
         st_ff.pos_c <= mcr_pkg::MCR_IN_SIGNAL;
         st_ff.neg_c <= mcr_pkg::MCR_IN_SIGNAL;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   assign lnk.stream_bit        = st_ff.bit_q;
   assign lnk.stream_valid_flag = st_ff.valid;
   assign o_bias_enable         = st_ff.bias;
   assign o_mod_clk_enable      = st_ff.clken;
   assign o_pos_conn            = st_ff.pos_c;
   assign o_neg_conn            = st_ff.neg_c;
endmodule
`default_nettype wire

// >>> logic/mcr_pkg.sv
// package: shared constants and types for the modulator control block
`default_nettype none
package mcr_pkg;
   // ---------------------------------------------------------------
   // timing counts in master clock cycles
   // ---------------------------------------------------------------
   localparam int unsigned VALID_HOLD_CYC = 20;
   localparam int unsigned SETTLE_CYC     = 1000;
   // ---------------------------------------------------------------
   // ones density patterns over an 8-cycle frame
   // ---------------------------------------------------------------
   localparam logic [7:0] DENS_50  = 8'h55; // 4 of 8
   localparam logic [7:0] DENS_375 = 8'h25; // 3 of 8
   localparam logic [7:0] DENS_625 = 8'had; // 5 of 8
   // ---------------------------------------------------------------
   // analog input connection selection
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MCR_IN_SIGNAL,
      MCR_IN_GROUND,
      MCR_IN_REF
   } mcr_conn_t;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [9:0] RST_SETTLE = 10'h000;
   localparam logic [4:0] RST_HOLD   = 5'h00;
endpackage
`default_nettype wire

// >>> logic/mcr_if.sv
// interface: bitstream link between modulator end and filter end
`default_nettype none
interface mcr_if;
   logic zero_cal_select;
   logic gain_cal_select;
   logic low_power_request;
   logic mod_reset;
   logic bipolar_mode;
   logic stream_bit;
   logic stream_valid_flag;
   modport dev (
      input  zero_cal_select,
      input  gain_cal_select,
      input  low_power_request,
      input  mod_reset,
      input  bipolar_mode,
      output stream_bit,
      output stream_valid_flag
   );
   modport host (
      output zero_cal_select,
      output gain_cal_select,
      output low_power_request,
      output mod_reset,
      output bipolar_mode,
      input  stream_bit,
      input  stream_valid_flag
   );
endinterface
`default_nettype wire

// >>> logic/mcr_host.sv
// module: filter end, drives controls and gates use of the bitstream
`default_nettype none
module mcr_host #(
   parameter int unsigned SETTLE = mcr_pkg::SETTLE_CYC
) (
   input  wire logic i_core_clk,
   input  wire logic i_rst,
   input  wire logic i_ce,
   mcr_if.host       lnk,
   input  wire logic i_zero_cal_req,
   input  wire logic i_gain_cal_req,
   input  wire logic i_low_power_req,
   input  wire logic i_reset_req,
   input  wire logic i_bipolar,
   output logic      o_bit,
   output logic      o_bit_usable,
   output logic      o_cal_needed
);
   typedef struct packed {
      logic [1:0] s_bit;
      logic [1:0] s_val;
      logic [9:0] settle;
      logic       zc;
      logic       gc;
      logic       lp;
      logic       rs;
      logic       bp;
      logic       bit_q;
      logic       use_q;
      logic       need;
   } mcr_host_state_t;

   mcr_host_state_t st_ff;
   mcr_host_state_t nxt_st;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s_bit = {st_ff.s_bit[0], lnk.stream_bit};
      nxt_st.s_val = {st_ff.s_val[0], lnk.stream_valid_flag};
      nxt_st.rs = i_reset_req;
      nxt_st.lp = i_low_power_req;
      nxt_st.bp = i_bipolar;
      // calibration only starts from a reset modulator
      nxt_st.zc = i_zero_cal_req & (st_ff.zc | st_ff.rs);
      nxt_st.gc = i_gain_cal_req & (st_ff.gc | st_ff.rs);
      // mode change voids earlier calibration
      if (i_bipolar != st_ff.bp) begin
         nxt_st.need = 1'b1;
      end else if ((st_ff.zc | st_ff.gc) && st_ff.settle == 10'(SETTLE)) begin
         nxt_st.need = 1'b0;
      end
      // settle window restarts on reset, cal entry, invalid flag
      if (st_ff.rs || !st_ff.s_val[1] || (nxt_st.zc & ~st_ff.zc)
          || (nxt_st.gc & ~st_ff.gc)) begin
         nxt_st.settle = mcr_pkg::RST_SETTLE;
      end else if (st_ff.settle != 10'(SETTLE)) begin
         nxt_st.settle = st_ff.settle + 10'h001;
      end
      nxt_st.bit_q = st_ff.s_bit[1];
      nxt_st.use_q = (st_ff.settle == 10'(SETTLE)) & st_ff.s_val[1]
                   & ~st_ff.lp;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff      <= '0;
         st_ff.need <= 1'b1;
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   assign lnk.zero_cal_select   = st_ff.zc;
   assign lnk.gain_cal_select   = st_ff.gc;
   assign lnk.low_power_request = st_ff.lp;
   assign lnk.mod_reset         = st_ff.rs;
   assign lnk.bipolar_mode      = st_ff.bp;
   assign o_bit                 = st_ff.bit_q;
   assign o_bit_usable          = st_ff.use_q;
   assign o_cal_needed          = st_ff.need;
endmodule
`default_nettype wire

// >>> verification/mcr_chk_sva.sv
// checker: link timing and stream density watch
`default_nettype none
module mcr_chk (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic zero_cal_select,
   input wire logic gain_cal_select,
   input wire logic low_power_request,
   input wire logic mod_reset,
   input wire logic bipolar_mode,
   input wire logic stream_bit,
   input wire logic stream_valid_flag
);
   logic [5:0] age_ff;
   logic [5:0] low_ff;
   logic [7:0] win_ff;
   logic [2:0] sel_ff;
   logic       aged;
   // ------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------
   // age restarts on any select change so a stale window never counts
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         age_ff <= 6'h00;
         low_ff <= 6'h00;
         win_ff <= 8'h00;
         sel_ff <= 3'h0;
      end else begin
         sel_ff <= {zero_cal_select, gain_cal_select, bipolar_mode};
         win_ff <= {win_ff[6:0], stream_bit};
         if (sel_ff != {zero_cal_select, gain_cal_select, bipolar_mode}
             || mod_reset || low_power_request)
            age_ff <= 6'h00;
         else if (age_ff != 6'h3f)
            age_ff <= age_ff + 6'h01;
         if (stream_valid_flag)
            low_ff <= 6'h00;
         else if (low_ff != 6'h3f)
            low_ff <= low_ff + 6'h01;
      end
   end
   // past sync, reset recovery and one full frame
   assign aged = (age_ff >= 6'h28);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   chk_valid_drop: assert property (
      mod_reset |-> ##[1:4] !stream_valid_flag) else $error("valid high");
   chk_valid_min_low: assert property (
      $rose(stream_valid_flag) |-> low_ff >= 6'h14) else $error("short low");
   chk_valid_release: assert property (
      $fell(mod_reset) && !low_power_request |-> ##[20:40] stream_valid_flag)
      else $error("valid late");
   chk_zero_bip_dens: assert property (
      aged && zero_cal_select && bipolar_mode |-> $countones(win_ff) == 4)
      else $error("zero bipolar density");
   chk_zero_uni_dens: assert property (
      aged && zero_cal_select && !bipolar_mode |-> $countones(win_ff) == 3)
      else $error("zero unipolar density");
   chk_gain_dens: assert property (
      aged && gain_cal_select && !zero_cal_select |-> $countones(win_ff) == 5)
      else $error("gain density");
   chk_bit_per_clk: assert property (
      aged && zero_cal_select && bipolar_mode
      |-> stream_bit != $past(stream_bit))
      else $error("bit not renewed");
   chk_standby_freeze: assert property (
      (low_power_request && !mod_reset) [*5] |-> $stable(stream_bit))
      else $error("bit moved in standby");
endmodule
`default_nettype wire

// >>> verification/modulator_cal_reset_control_tb.sv
// testbench: both link ends joined, driven from the filter side
`default_nettype none
module modulator_cal_reset_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SETL = 16; // short settle keeps the run brief
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic zero_req = 1'b0, gain_req = 1'b0, lp_req = 1'b0;
   logic rst_req = 1'b0, bip = 1'b0;
   logic [15:0] pos = 16'h8000, neg = 16'h8000, refl = 16'h4000;
   logic bias_en, clk_en, hbit, usable, cal_need;
   mcr_pkg::mcr_conn_t pos_c, neg_c;
   int n_mismatch = 0, checks = 0, cyc = 0;
   // ------------------------------------------------------------
   // structure
   // ------------------------------------------------------------
   always #50 clk = ~clk;
   mcr_if lnk ();
   mcr_dev mcr_dev_i (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1),
      .lnk(lnk.dev), .i_pos_analog_input(pos), .i_neg_analog_input(neg),
      .i_ref_level(refl), .o_bias_enable(bias_en),
      .o_mod_clk_enable(clk_en), .o_pos_conn(pos_c), .o_neg_conn(neg_c));
   mcr_host #(.SETTLE(SETL)) mcr_host_i (.i_core_clk(clk), .i_rst(rst),
      .i_ce(1'b1), .lnk(lnk.host), .i_zero_cal_req(zero_req),
      .i_gain_cal_req(gain_req), .i_low_power_req(lp_req),
      .i_reset_req(rst_req), .i_bipolar(bip), .o_bit(hbit),
      .o_bit_usable(usable), .o_cal_needed(cal_need));
   mcr_chk mcr_chk_i (.i_core_clk(clk), .i_rst(rst),
      .zero_cal_select(lnk.zero_cal_select),
      .gain_cal_select(lnk.gain_cal_select),
      .low_power_request(lnk.low_power_request),
      .mod_reset(lnk.mod_reset), .bipolar_mode(lnk.bipolar_mode),
      .stream_bit(lnk.stream_bit),
      .stream_valid_flag(lnk.stream_valid_flag));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_in(input int v, input int lo, input int hi);
      checks++;
      if (v < lo || v > hi) begin
         n_mismatch++;
         $display("wrong value at %0t: %0d not in %0d..%0d", $time, v, lo, hi);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   // low cycles are counted at falling edges, bounded against a hang
   task automatic count_low(output int n);
      n = 0;
      while (lnk.stream_valid_flag !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic do_cal(input logic z, g, b, input int ones,
                         input mcr_pkg::mcr_conn_t ep, en);
      int n;
      int k;
      int kh;
      bip = b;
      step(4);
      rst_req = 1'b1;
      step(2);
      zero_req = z;
      gain_req = g;
      step(2);
      rst_req = 1'b0;
      count_low(n);
      chk_in(n, 21, 27);
      chk(8'(usable), 8'h00);
      step(SETL + 8);
      chk(8'(usable), 8'h01);
      chk(8'(pos_c), 8'(ep));
      chk(8'(neg_c), 8'(en));
      k = 0;
      kh = 0;
      repeat (8) begin
         step(1);
         k += (lnk.stream_bit === 1'b1);
         kh += (hbit === 1'b1);
      end
      chk_in(k, ones, ones);
      chk_in(kh, ones, ones);
      chk(8'(cal_need), 8'h00);
      zero_req = 1'b0;
      gain_req = 1'b0;
      step(6);
   endtask
   task automatic standby();
      logic b;
      lp_req = 1'b1;
      step(8);
      chk(8'({bias_en, clk_en}), 8'h00);
      b = lnk.stream_bit;
      step(4);
      chk(8'(lnk.stream_bit), 8'(b));
      lp_req = 1'b0;
      step(8);
      chk(8'({bias_en, clk_en}), 8'h03);
   endtask
   // overdrive until the flag falls, then recover with a quiet input
   task automatic overrange();
      int n;
      pos = 16'hffff;
      neg = 16'h0000;
      refl = 16'h0001;
      n = 0;
      while (lnk.stream_valid_flag === 1'b1 && n < 3000) begin
         step(1);
         n++;
      end
      chk_in(n, 0, 2999);
      pos = 16'h8000;
      neg = 16'h8000;
      refl = 16'h4000;
      count_low(n);
      chk_in(n, 18, 24);
      repeat (40) begin
         step(1);
         chk(8'(lnk.stream_valid_flag), 8'h01);
      end
   endtask
   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial begin
      step(20);
      rst = 1'b0;
      step(2);
      zero_req = 1'b1;
      step(4);
      chk(8'(lnk.zero_cal_select), 8'h00);
      zero_req = 1'b0;
      do_cal(1'b1, 1'b0, 1'b1, 4, mcr_pkg::MCR_IN_REF, mcr_pkg::MCR_IN_REF);
      do_cal(1'b1, 1'b0, 1'b0, 3, mcr_pkg::MCR_IN_GROUND,
             mcr_pkg::MCR_IN_GROUND);
      do_cal(1'b0, 1'b1, 1'b0, 5, mcr_pkg::MCR_IN_REF, mcr_pkg::MCR_IN_GROUND);
      do_cal(1'b0, 1'b1, 1'b1, 5, mcr_pkg::MCR_IN_REF, mcr_pkg::MCR_IN_GROUND);
      bip = 1'b0;
      step(4);
      chk(8'(cal_need), 8'h01);
      standby();
      overrange();
      tally_and_finish();
   end
endmodule
`default_nettype wire
